// ===== src/adc_ctrl_params.svh
// Constants for the operating-mode and calibration controller
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH
`define CTRL_W 24
`define CTRL_RST 24'h000000
`define MODE_HI 23
`define MODE_LO 21
`define GAIN_HI 20
`define GAIN_LO 18
`define CH_BIT 17
`define PD_BIT 16
`define WL_BIT 15
`define BIAS_BIT 14
`define FAULT_BIT 13
`define POL_BIT 12
`define FILT_HI 11
`define FILT_LO 0
`define MODE_NORMAL 3'h0
`define MODE_SELF 3'h1
`define MODE_SYS_ZERO 3'h2
`define MODE_SYS_FULL 3'h3
`define MODE_OFFSET 3'h4
`define MODE_BG 3'h5
`define MODE_ZS_COEF 3'h6
`define MODE_FS_COEF 3'h7
`define WORD_FULL 5'h18
`define WORD_SHORT 5'h10
`define TOP_BIT 5'h17
`define BG_LAST 3'h5
`define BG_CONV 3'h0
`define BG_ZERO_DONE 3'h2
`define BG_REF_FROM 3'h3
`define BG_FULL_DONE 3'h4
`define SEL_ZERO 1'h0
`define SEL_FULL 1'h1
`endif

// ===== src/adc_ctrl_pkg.sv
// Types shared by the controller and its coefficient store
package adc_ctrl_pkg;
  typedef enum {CAL_IDLE, CAL_ZERO, CAL_FULL} cal_state_t;
  typedef enum logic [1:0] {ROUTE_CHAN, ROUTE_SHORT, ROUTE_REF} route_t;
endpackage : adc_ctrl_pkg

// ===== src/coef_port_if.sv
// Port between the controller and its coefficient store
`timescale 1ns/1ns
`default_nettype none
interface coef_port_if;
  logic we;
  logic [1:0] waddr;
  logic [23:0] wdata;
  logic [1:0] raddr;
  logic [23:0] rdata;
  modport owner (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : coef_port_if
`default_nettype wire

// ===== src/coef_store.sv
// Zero-scale and full-scale coefficients, one pair per input channel
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctrl_params.svh"
module coef_store
  import adc_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  coef_port_if.store cp
);
  logic [23:0] mem [4];
  logic [23:0] rdata_ff;
  logic [23:0] nxt_rdata;

  always_comb begin
    nxt_rdata = mem[cp.raddr];
  end

  always_ff @(posedge ref_clk) begin
    if (cp.we) begin
      mem[cp.waddr] <= cp.wdata;
    end
    if (rst) begin
      rdata_ff <= `CTRL_RST;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign cp.rdata = rdata_ff;
endmodule : coef_store
`default_nettype wire

// ===== src/adc_mode_calibration_control.sv
// Operating-mode and calibration controller with its serial register port
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctrl_params.svh"
module adc_mode_calibration_control
  import adc_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic link_sclk,
  input wire logic transmit_frame_n,
  input wire logic receive_frame_n,
  input wire logic register_select,
  input wire logic sdata_in,
  output logic sdata_out,
  output logic sdata_oe,
  output logic data_ready_n,
  input wire logic meas_valid,
  input wire logic [23:0] meas_data,
  output logic [1:0] meas_route,
  output logic [23:0] control_word
);
  function automatic logic is_coef(input logic [2:0] m);
    return (m == `MODE_ZS_COEF) || (m == `MODE_FS_COEF);
  endfunction : is_coef

  function automatic cal_state_t start_state(input logic [2:0] m);
    case (m)
      `MODE_SELF, `MODE_SYS_ZERO, `MODE_OFFSET: return CAL_ZERO;
      `MODE_SYS_FULL: return CAL_FULL;
      default: return CAL_IDLE;
    endcase
  endfunction : start_state

  function automatic route_t route_of(input cal_state_t s, input logic [2:0] m,
                                      input logic [2:0] slot);
    route_t r;
    r = ROUTE_CHAN;
    case (s)
      CAL_ZERO: r = (m == `MODE_SELF) ? ROUTE_SHORT : ROUTE_CHAN;
      CAL_FULL: r = (m == `MODE_SYS_FULL) ? ROUTE_CHAN : ROUTE_REF;
      default: begin
        if (m == `MODE_BG && slot != `BG_CONV && slot < `BG_REF_FROM) begin
          r = ROUTE_SHORT;
        end else if (m == `MODE_BG && slot >= `BG_REF_FROM && slot <= `BG_FULL_DONE) begin
          r = ROUTE_REF;
        end
      end
    endcase
    return r;
  endfunction : route_of

  ////////////////////////////////////////////////////////////////////////////
  // Shared state declarations
  logic [23:0] ctrl_ff, nxt_ctrl;
  cal_state_t state_ff, nxt_state;
  logic [2:0] slot_ff, nxt_slot;
  logic [23:0] result_ff, nxt_result;
  logic [23:0] dat_word_ff, nxt_dat_word;
  logic data_ready_n_n_ff, nxt_data_ready_n_n;
  logic cal_done, publish;
  logic [2:0] mode;
  logic ch;
  coef_port_if cw ();

  assign mode = ctrl_ff[`MODE_HI:`MODE_LO];
  assign ch = ctrl_ff[`CH_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Link side: write frames, bit counter and shifter cleared while the frame pin is high
  logic [4:0] wr_cnt_ff, nxt_wr_cnt;
  logic [23:0] wr_sh_ff, nxt_wr_sh;
  logic [23:0] wr_word_ff, nxt_wr_word;
  logic wr_sel_ff, nxt_wr_sel;
  logic wr_tgl_ff, nxt_wr_tgl;

  always_comb begin
    nxt_wr_cnt = wr_cnt_ff;
    nxt_wr_sh = wr_sh_ff;
    nxt_wr_word = wr_word_ff;
    nxt_wr_sel = wr_sel_ff;
    nxt_wr_tgl = wr_tgl_ff;
    if (wr_cnt_ff != `WORD_FULL) begin
      nxt_wr_sh = {wr_sh_ff[22:0], sdata_in};
      nxt_wr_cnt = wr_cnt_ff + 5'h01;
      if (wr_cnt_ff == `TOP_BIT) begin
        nxt_wr_word = {wr_sh_ff[22:0], sdata_in};
        nxt_wr_sel = register_select;
        nxt_wr_tgl = ~wr_tgl_ff;
      end
    end
  end

  always_ff @(posedge link_sclk or posedge transmit_frame_n) begin
    if (transmit_frame_n) begin
      wr_cnt_ff <= 5'h00;
      wr_sh_ff <= `CTRL_RST;
    end else begin
      wr_cnt_ff <= nxt_wr_cnt;
      wr_sh_ff <= nxt_wr_sh;
    end
  end

  always_ff @(posedge link_sclk or posedge rst) begin
    if (rst) begin
      wr_word_ff <= `CTRL_RST;
      wr_sel_ff <= 1'h0;
      wr_tgl_ff <= 1'h0;
    end else begin
      wr_word_ff <= nxt_wr_word;
      wr_sel_ff <= nxt_wr_sel;
      wr_tgl_ff <= nxt_wr_tgl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link side: read frames
  logic [4:0] rd_cnt_ff, nxt_rd_cnt;
  logic rd_tgl_ff, nxt_rd_tgl;
  logic [4:0] rd_len;
  logic rd_data;
  logic [23:0] rd_word;

  assign rd_data = register_select && !is_coef(mode);
  assign rd_len = (rd_data && !ctrl_ff[`WL_BIT]) ? `WORD_SHORT : `WORD_FULL;
  assign rd_word = register_select ? dat_word_ff : ctrl_ff;

  always_comb begin
    nxt_rd_cnt = rd_cnt_ff;
    nxt_rd_tgl = rd_tgl_ff;
    if (rd_cnt_ff < rd_len) begin
      nxt_rd_cnt = rd_cnt_ff + 5'h01;
      if (rd_cnt_ff == rd_len - 5'h01 && rd_data) begin
        nxt_rd_tgl = ~rd_tgl_ff;
      end
    end
  end

  always_ff @(posedge link_sclk or posedge receive_frame_n) begin
    if (receive_frame_n) begin
      rd_cnt_ff <= 5'h00;
    end else begin
      rd_cnt_ff <= nxt_rd_cnt;
    end
  end

  always_ff @(posedge link_sclk or posedge rst) begin
    if (rst) begin
      rd_tgl_ff <= 1'h0;
    end else begin
      rd_tgl_ff <= nxt_rd_tgl;
    end
  end

  assign sdata_oe = !receive_frame_n && (rd_cnt_ff < rd_len);
  assign sdata_out = sdata_oe ? rd_word[`TOP_BIT - rd_cnt_ff] : 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Crossings into the reference clock domain
  logic [2:0] wr_s_ff, nxt_wr_s;
  logic [2:0] rd_s_ff, nxt_rd_s;
  logic [1:0] rfs_s_ff, nxt_rfs_s;
  logic wr_evt, rd_evt;

  always_comb begin
    nxt_wr_s = {wr_s_ff[1:0], wr_tgl_ff};
    nxt_rd_s = {rd_s_ff[1:0], rd_tgl_ff};
    nxt_rfs_s = {rfs_s_ff[0], receive_frame_n};
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_s_ff <= 3'h0;
      rd_s_ff <= 3'h0;
      rfs_s_ff <= 2'h3;
    end else begin
      wr_s_ff <= nxt_wr_s;
      rd_s_ff <= nxt_rd_s;
      rfs_s_ff <= nxt_rfs_s;
    end
  end

  assign wr_evt = wr_s_ff[1] ^ wr_s_ff[2];
  assign rd_evt = rd_s_ff[1] ^ rd_s_ff[2];

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencing, calibration and data ready
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_state = state_ff;
    nxt_slot = slot_ff;
    nxt_result = result_ff;
    nxt_data_ready_n_n = data_ready_n_n_ff;
    nxt_dat_word = dat_word_ff;
    cw.we = 1'h0;
    cw.waddr = {`SEL_ZERO, ch};
    cw.wdata = meas_data;
    cw.raddr = {(mode == `MODE_FS_COEF), ch};
    cal_done = 1'h0;
    publish = 1'h0;
    if (rd_evt) begin
      nxt_data_ready_n_n = 1'h1;
    end
    case (state_ff)
      CAL_IDLE: begin
        if (meas_valid && mode == `MODE_NORMAL) begin
          publish = 1'h1;
        end else if (meas_valid && mode == `MODE_BG) begin
          publish = (slot_ff == `BG_CONV);
          cw.we = (slot_ff == `BG_ZERO_DONE) || (slot_ff == `BG_FULL_DONE);
          cw.waddr = {(slot_ff == `BG_FULL_DONE), ch};
          nxt_slot = (slot_ff == `BG_LAST) ? `BG_CONV : slot_ff + 3'h1;
        end
      end
      CAL_ZERO: begin
        if (meas_valid) begin
          cw.we = 1'h1;
          if (mode == `MODE_SELF || mode == `MODE_OFFSET) begin
            nxt_state = CAL_FULL;
          end else begin
            cal_done = 1'h1;
          end
        end
      end
      CAL_FULL: begin
        if (meas_valid) begin
          cw.we = 1'h1;
          cw.waddr = {`SEL_FULL, ch};
          cal_done = 1'h1;
        end
      end
      default: nxt_state = CAL_IDLE;
    endcase
    if (cal_done) begin
      nxt_state = CAL_IDLE;
      nxt_ctrl[`MODE_HI:`MODE_LO] = `MODE_NORMAL;
      nxt_data_ready_n_n = 1'h0;
    end
    if (publish) begin
      nxt_result = meas_data;
      nxt_data_ready_n_n = 1'h0;
    end
    if (wr_evt && wr_sel_ff && is_coef(mode)) begin
      cw.we = 1'h1;
      cw.waddr = {(mode == `MODE_FS_COEF), ch};
      cw.wdata = wr_word_ff;
    end
    if (wr_evt && !wr_sel_ff) begin
      nxt_ctrl = wr_word_ff;
      nxt_slot = `BG_CONV;
      nxt_state = start_state(wr_word_ff[`MODE_HI:`MODE_LO]);
    end
    if (rfs_s_ff[1]) begin
      nxt_dat_word = is_coef(mode) ? cw.rdata : result_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_ff <= `CTRL_RST;
      state_ff <= CAL_IDLE;
      slot_ff <= `BG_CONV;
      result_ff <= `CTRL_RST;
      dat_word_ff <= `CTRL_RST;
      data_ready_n_n_ff <= 1'h1;
    end else begin
      ctrl_ff <= nxt_ctrl;
      state_ff <= nxt_state;
      slot_ff <= nxt_slot;
      result_ff <= nxt_result;
      dat_word_ff <= nxt_dat_word;
      data_ready_n_n_ff <= nxt_data_ready_n_n;
    end
  end

  coef_store u_store (
    .ref_clk(ref_clk),
    .rst(rst),
    .cp(cw.store)
  );

  assign data_ready_n = data_ready_n_n_ff;
  assign control_word = ctrl_ff;
  assign meas_route = route_of(state_ff, mode, slot_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence ctrl_write_s;
    wr_evt && !wr_sel_ff;
  endsequence

  sequence cal_end_s;
    (state_ff != CAL_IDLE) && meas_valid && cal_done;
  endsequence

  reset_mode_a: assert property (@(posedge ref_clk) $past(rst) |-> mode == `MODE_NORMAL)
    else $error("mode not normal after reset");

  ctrl_load_a: assert property (@(posedge ref_clk) disable iff (rst)
    ctrl_write_s |=> ctrl_ff == $past(wr_word_ff))
    else $error("control word not loaded");

  self_start_a: assert property (@(posedge ref_clk) disable iff (rst)
    ctrl_write_s ##0 (wr_word_ff[`MODE_HI:`MODE_LO] == `MODE_SELF)
    |=> state_ff == CAL_ZERO && meas_route == ROUTE_SHORT)
    else $error("self calibration not started on shorted input");

  self_ref_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == CAL_FULL && mode == `MODE_SELF) |-> meas_route == ROUTE_REF)
    else $error("self calibration full scale not on reference");
  offset_route_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == CAL_ZERO && mode == `MODE_OFFSET) |-> meas_route == ROUTE_CHAN)
    else $error("offset zero scale not on channel");
  cal_finish_a: assert property (@(posedge ref_clk) disable iff (rst)
    cal_end_s ##0 !wr_evt |=> mode == `MODE_NORMAL && !data_ready_n && state_ff == CAL_IDLE)
    else $error("calibration end not reported");
  zs_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_evt && wr_sel_ff && mode == `MODE_ZS_COEF)
    |-> cw.we && cw.waddr == {`SEL_ZERO, ch} && cw.wdata == wr_word_ff)
    else $error("zero coefficient write misdirected");
  fs_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_evt && wr_sel_ff && mode == `MODE_FS_COEF)
    |-> cw.we && cw.waddr == {`SEL_FULL, ch})
    else $error("full coefficient write misdirected");
  bg_rate_a: assert property (@(posedge ref_clk) disable iff (rst)
    (publish && mode == `MODE_BG) |-> slot_ff == `BG_CONV)
    else $error("background word outside conversion slot");
  bg_update_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == CAL_IDLE && mode == `MODE_BG && meas_valid && slot_ff == `BG_FULL_DONE)
    |-> cw.we && cw.waddr == {`SEL_FULL, ch})
    else $error("background full scale not stored");

  coef_len_a: assert property (@(posedge ref_clk) disable iff (rst)
    is_coef(mode) |-> rd_len == `WORD_FULL)
    else $error("coefficient transfer not 24 bits");

  normal_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    (rfs_s_ff[1] && mode == `MODE_NORMAL) |=> dat_word_ff == $past(result_ff))
    else $error("data word not the conversion result");

  data_ready_n_rise_a: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_evt && !publish && !cal_done) |=> data_ready_n)
    else $error("data ready not released after read");
endmodule : adc_mode_calibration_control
`default_nettype wire

// ===== tb/host_model.sv
// Host microcontroller model driving the serial control port
`timescale 1ns/1ns
`default_nettype none
module host_model (
  output logic link_sclk,
  output logic transmit_frame_n,
  output logic receive_frame_n,
  output logic register_select,
  output logic sdata_in,
  input wire logic sdata_out,
  input wire logic sdata_oe
);
  initial begin
    link_sclk = 1'b0;
    transmit_frame_n = 1'b1;
    receive_frame_n = 1'b1;
    register_select = 1'b0;
    sdata_in = 1'b0;
  end

  // Link clock runs only inside frames, period 32 ns
  task automatic pulse;
    #16 link_sclk = 1'b1;
    #16 link_sclk = 1'b0;
  endtask : pulse

  // Sends nbits, MSB first; bits past the 24th carry a changing filler
  task automatic write_word(input logic sel, input logic [23:0] word, input int nbits);
    register_select = sel;
    #16 transmit_frame_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      sdata_in = (i < 24) ? word[23 - i] : ~sdata_in;
      pulse();
    end
    #16 transmit_frame_n = 1'b1;
    sdata_in = ~sdata_in;
    #300;
  endtask : write_word

  // Gap after each frame keeps the spacing the port needs
  task automatic read_word(input logic sel, input int nbits, output logic [23:0] word);
    word = 24'h000000;
    register_select = sel;
    #16 receive_frame_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      // Undriven line reads the opposite level, so a late release shows up
      #8 word = {word[22:0], sdata_oe ? sdata_out : ~sdata_out};
      #8 link_sclk = 1'b1;
      #16 link_sclk = 1'b0;
    end
    #16 receive_frame_n = 1'b1;
    #300;
  endtask : read_word
endmodule : host_model
`default_nettype wire

// ===== tb/adc_mode_calibration_control_tb.sv
// Self-checking bench for the mode and calibration controller
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctrl_params.svh"
module adc_mode_calibration_control_tb
  import adc_ctrl_pkg::*;
();
  typedef struct {logic [2:0] mode; int steps; logic [1:0] r0; logic [1:0] r1;} cal_row_t;
  logic ref_clk, rst, meas_valid, link_sclk, transmit_frame_n, receive_frame_n;
  logic register_select, sdata_in, sdata_out, sdata_oe, data_ready_n;
  logic [23:0] meas_data, control_word, rd, cw;
  logic [1:0] meas_route;
  int fail_count, checked, falls;
  cal_row_t rows[4] = '{'{`MODE_SELF, 2, ROUTE_SHORT, ROUTE_REF},
    '{`MODE_SYS_ZERO, 1, ROUTE_CHAN, ROUTE_CHAN}, '{`MODE_SYS_FULL, 1, ROUTE_CHAN, ROUTE_CHAN},
    '{`MODE_OFFSET, 2, ROUTE_CHAN, ROUTE_REF}};

  adc_mode_calibration_control adc_mode_calibration_control_inst (
    .ref_clk(ref_clk), .rst(rst), .link_sclk(link_sclk), .transmit_frame_n(transmit_frame_n),
    .receive_frame_n(receive_frame_n), .register_select(register_select),
    .sdata_in(sdata_in), .sdata_out(sdata_out), .sdata_oe(sdata_oe),
    .data_ready_n(data_ready_n), .meas_valid(meas_valid), .meas_data(meas_data),
    .meas_route(meas_route), .control_word(control_word));
  host_model host_model_inst (
    .link_sclk(link_sclk), .transmit_frame_n(transmit_frame_n),
    .receive_frame_n(receive_frame_n), .register_select(register_select),
    .sdata_in(sdata_in), .sdata_out(sdata_out), .sdata_oe(sdata_oe));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic pulse_meas(input logic [23:0] d);
    @(posedge ref_clk);
    meas_valid <= 1'b1;
    meas_data <= d;
    @(posedge ref_clk);
    meas_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : pulse_meas

  // Host frames end at any time; outputs are then looked at mid-cycle
  task automatic wr(input logic sel, input logic [23:0] w, input int n);
    host_model_inst.write_word(sel, w, n);
    @(negedge ref_clk);
  endtask : wr

  task automatic rdw(input logic sel, output logic [23:0] w);
    host_model_inst.read_word(sel, 24, w);
    @(negedge ref_clk);
  endtask : rdw

  function automatic logic [23:0] ctrl(input logic [2:0] mode, input logic wl);
    return {mode, 3'h2, 1'h1, 1'h0, wl, 3'h0, 12'h0C8};
  endfunction : ctrl

  initial begin
    #1000000;
    fail_count++;
    $display("Error watchdog expired");
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    fail_count = 0;
    checked = 0;
    rst = 1'b1;
    meas_valid = 1'b0;
    meas_data = 24'h000000;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    foreach (rows[i]) begin
      cw = ctrl(rows[i].mode, 1'b1);
      wr(1'b0, cw, 24);
      check("mode loaded", {21'h0, control_word[23:21]}, {21'h0, rows[i].mode});
      check("first route", {22'h0, meas_route}, {22'h0, rows[i].r0});
      pulse_meas(24'h111111);
      if (rows[i].steps == 2) begin
        check("second route", {22'h0, meas_route}, {22'h0, rows[i].r1});
        pulse_meas(24'h222222);
      end
      check("mode cleared", control_word, {3'h0, cw[20:0]});
      check("cal done ready", {23'h0, data_ready_n}, 24'h000000);
      rdw(1'b1, rd);
      check("ready after read", {23'h0, data_ready_n}, 24'h000001);
      $display("Test calibration row %0d done", i);
    end
    cw = ctrl(`MODE_NORMAL, 1'b1);
    wr(1'b0, cw, 24);
    pulse_meas(24'hA5C3F0);
    check("new word ready", {23'h0, data_ready_n}, 24'h000000);
    rdw(1'b1, rd);
    check("data read", rd, 24'hA5C3F0);
    check("ready released", {23'h0, data_ready_n}, 24'h000001);
    rdw(1'b0, rd);
    check("control read", rd, cw);
    wr(1'b0, 24'h200000, 12);
    check("short control", control_word, cw);
    wr(1'b0, 24'h1ABABC, 30);
    check("long control", control_word, 24'h1ABABC);
    // Sixteen-bit data word: the line must be released after bit 16
    wr(1'b0, ctrl(`MODE_NORMAL, 1'b0), 24);
    pulse_meas(24'h5A3C0F);
    fork
      rdw(1'b1, rd);
      begin
        @(negedge receive_frame_n);
        @(negedge ref_clk);
        check("oe in frame", {23'h0, sdata_oe}, 24'h000001);
      end
    join
    check("short data read", rd, 24'h5A3CFF);
    check("oe released", {23'h0, sdata_oe}, 24'h000000);
    check("short read ready", {23'h0, data_ready_n}, 24'h000001);
    $display("Test normal and control done");
    wr(1'b0, ctrl(`MODE_ZS_COEF, 1'b0), 24);
    wr(1'b1, 24'h123456, 24);
    rdw(1'b1, rd);
    check("zero coef", rd, 24'h123456);
    wr(1'b0, ctrl(`MODE_FS_COEF, 1'b0), 24);
    wr(1'b1, 24'h654321, 24);
    wr(1'b1, 24'hFFFFFF, 16);
    rdw(1'b1, rd);
    check("full coef", rd, 24'h654321);
    $display("Test coefficients done");
    wr(1'b0, ctrl(`MODE_BG, 1'b1), 24);
    falls = 0;
    for (int k = 0; k < 12; k++) begin
      pulse_meas(24'h300000 + 24'(k));
      if (data_ready_n === 1'b0) begin
        falls++;
        rdw(1'b1, rd);
      end
    end
    check("background words", 24'(falls), 24'h000002);
    // Slots 2 and 4 of the second round hold the latest stored points
    wr(1'b0, ctrl(`MODE_ZS_COEF, 1'b1), 24);
    rdw(1'b1, rd);
    check("zero coef refreshed", rd, 24'h300008);
    wr(1'b0, ctrl(`MODE_FS_COEF, 1'b1), 24);
    rdw(1'b1, rd);
    check("full coef refreshed", rd, 24'h30000A);
    $display("Test background done");
    // Reset in the middle of a self-calibration
    wr(1'b0, ctrl(`MODE_SELF, 1'b1), 24);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check("reset control", control_word, `CTRL_RST);
    check("reset route", {22'h0, meas_route}, 24'h000000);
    check("reset ready", {23'h0, data_ready_n}, 24'h000001);
    $display("Test reset done");
    finish_test();
  end
endmodule : adc_mode_calibration_control_tb
`default_nettype wire
